// file: hdl/tec_counter.v
`timescale 1ns/1ps
`include "tec_regs.vh"
// How it works
// - three independent axes X, Y, Z, each with its own mode
// - mode 1 cw/ccw, 2 pulse plus direction, 3 a/b quadrature
// - any other mode value behaves as mode 1
// - inversion setting 1 inverts every encoder input, 0 passes them
// - pulse/direction, not inverted: pulses count up while direction high
// - pulse/direction, inverted: pulses count down while physical direction high
// - three index flags follow each axis z-index input
// - start enables counting on selected axis; host issues it once
// - stop halts counting so edges no longer change the count
// - get snapshots count into a register no bus address reads, and returns a flag true while counting
// - reset loads the count with a host value, any value
// - start, stop, state, reset return success true or error false
module tec_counter #(
   parameter CW = 32
) (
   // apb
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // encoder pins, a/b/z per axis, bit 0 x, 1 y, 2 z
   input  wire [2:0]  enc_a,
   input  wire [2:0]  enc_b,
   input  wire [2:0]  enc_z,
   // index flags
   output reg         x_index_flag,
   output reg         y_index_flag,
   output reg         z_index_flag
);
   ////////////////////////////////////////////////////////////////////////////
   reg  [31:0]   cfg_ff;
   reg  [CW-1:0] value_ff;
   reg  [CW-1:0] rd_val_ff;
   reg           res_q_ff;
   reg           res_done_ff;
   reg  [2:0]    run_ff;
   reg  [2:0]    load_ff;
   reg  [8:0]    s1_ff;
   reg  [8:0]    s2_ff;
   wire [CW-1:0] cnt_x;
   wire [CW-1:0] cnt_y;
   wire [CW-1:0] cnt_z;
   wire [8:0]    pins;
   wire          inv;
   wire          wr;
   wire          rd;
   wire [2:0]    op;
   wire [1:0]    ch;
   wire          ch_ok;
   reg  [CW-1:0] ch_cnt;
   reg  [31:0]   nxt_prdata;
   reg           nxt_pslverr;

   assign inv  = cfg_ff[`TEC_CFG_INV_BIT];
   assign pins = {enc_z, enc_b, enc_a};
   assign wr   = psel & penable & pwrite;
   assign rd   = psel & ~penable & ~pwrite;
   assign op   = pwdata[`TEC_CMD_OP_LSB +: 3];
   assign ch   = pwdata[`TEC_CMD_CH_LSB +: 2];
   assign ch_ok = (ch != 2'h3);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers, inversion applied between the first and second stage
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= 9'h000;
         s2_ff <= 9'h000;
      end else begin
         s1_ff <= pins;
         s2_ff <= s1_ff ^ {9{inv}};
      end
   end

   // index flags follow the corrected z inputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_index_flag <= 1'b0;
         y_index_flag <= 1'b0;
         z_index_flag <= 1'b0;
      end else begin
         x_index_flag <= s2_ff[6];
         y_index_flag <= s2_ff[7];
         z_index_flag <= s2_ff[8];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axes
   tec_axis #(.CW(CW)) u_x (
      .pclk     (pclk),
      .presetn  (presetn),
      .in_a     (s2_ff[0]),
      .in_b     (s2_ff[3]),
      .mode     (cfg_ff[`TEC_CFG_XMODE_LSB +: 2]),
      .run      (run_ff[0]),
      .load     (load_ff[0]),
      .load_val (value_ff),
      .count_ff (cnt_x)
   );
   tec_axis #(.CW(CW)) u_y (
      .pclk     (pclk),
      .presetn  (presetn),
      .in_a     (s2_ff[1]),
      .in_b     (s2_ff[4]),
      .mode     (cfg_ff[`TEC_CFG_YMODE_LSB +: 2]),
      .run      (run_ff[1]),
      .load     (load_ff[1]),
      .load_val (value_ff),
      .count_ff (cnt_y)
   );
   tec_axis #(.CW(CW)) u_z (
      .pclk     (pclk),
      .presetn  (presetn),
      .in_a     (s2_ff[2]),
      .in_b     (s2_ff[5]),
      .mode     (cfg_ff[`TEC_CFG_ZMODE_LSB +: 2]),
      .run      (run_ff[2]),
      .load     (load_ff[2]),
      .load_val (value_ff),
      .count_ff (cnt_z)
   );

   always @* begin
      case (ch)
         2'h0:    ch_cnt = cnt_x;
         2'h1:    ch_cnt = cnt_y;
         2'h2:    ch_cnt = cnt_z;
         default: ch_cnt = {CW{1'b0}};
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // command execution on a write to the command register
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff      <= `TEC_CFG_RST;
         value_ff    <= {CW{1'b0}};
         rd_val_ff   <= {CW{1'b0}};
         res_q_ff    <= 1'b0;
         res_done_ff <= 1'b0;
         run_ff      <= 3'h0;
         load_ff     <= 3'h0;
      end else begin
         load_ff <= 3'h0;
         if (wr && paddr == `TEC_OFF_CFG) begin
            cfg_ff <= pwdata & 32'h0000_013f;
         end
         if (wr && paddr == `TEC_OFF_VALUE) begin
            value_ff <= pwdata[CW-1:0];
         end
         if (wr && paddr == `TEC_OFF_CMD) begin
            res_done_ff <= 1'b1;
            res_q_ff    <= 1'b0;
            case (op)
               `TEC_OP_START: begin
                  if (ch_ok) begin
                     run_ff[ch] <= 1'b1;
                     res_q_ff   <= 1'b1;
                  end
               end
               `TEC_OP_STOP: begin
                  if (ch_ok) begin
                     run_ff[ch] <= 1'b0;
                     res_q_ff   <= 1'b1;
                  end
               end
               `TEC_OP_GET: begin
                  // q reports counting state, count snapshot has no read address
                  rd_val_ff <= ch_cnt;
                  res_q_ff  <= ch_ok & run_ff[ch];
               end
               `TEC_OP_STATE: begin
                  res_q_ff <= ch_ok;
               end
               `TEC_OP_RESET: begin
                  if (ch_ok) begin
                     load_ff[ch] <= 1'b1;
                     res_q_ff    <= 1'b1;
                  end
               end
               default: begin
                  res_q_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb read mux, answer in the access cycle
   always @* begin
      nxt_prdata  = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      case (paddr)
         `TEC_OFF_CFG:    nxt_prdata = cfg_ff;
         `TEC_OFF_CMD:    nxt_prdata = 32'h0000_0000;
         `TEC_OFF_VALUE:  nxt_prdata = value_ff;
         `TEC_OFF_RESULT: nxt_prdata = {30'h0, res_done_ff, res_q_ff};
         `TEC_OFF_STATUS: nxt_prdata = {25'h0, x_index_flag & 1'b0, z_index_flag, y_index_flag,
                                        x_index_flag, run_ff};
         `TEC_OFF_CNT_X:  nxt_prdata = cnt_x;
         `TEC_OFF_CNT_Y:  nxt_prdata = cnt_y;
         `TEC_OFF_CNT_Z:  nxt_prdata = cnt_z;
         default:         nxt_pslverr = 1'b1;
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & nxt_pslverr;
         if (rd) begin
            prdata <= nxt_prdata;
         end
      end
   end
endmodule // tec_counter

// file: shared/tec_regs.vh
`ifndef TEC_REGS_VH
`define TEC_REGS_VH
// register byte offsets
`define TEC_OFF_CFG     12'h000
`define TEC_OFF_CMD     12'h004
`define TEC_OFF_VALUE   12'h008
`define TEC_OFF_RESULT  12'h00c
`define TEC_OFF_STATUS  12'h010
`define TEC_OFF_CNT_X   12'h014
`define TEC_OFF_CNT_Y   12'h018
`define TEC_OFF_CNT_Z   12'h01c
// cfg fields
`define TEC_CFG_XMODE_LSB 0
`define TEC_CFG_YMODE_LSB 2
`define TEC_CFG_ZMODE_LSB 4
`define TEC_CFG_INV_BIT   8
`define TEC_CFG_RST       32'h0000_0015
// cmd fields
`define TEC_CMD_OP_LSB  0
`define TEC_CMD_CH_LSB  4
// command codes
`define TEC_OP_START    3'h1
`define TEC_OP_STOP     3'h2
`define TEC_OP_GET      3'h3
`define TEC_OP_STATE    3'h4
`define TEC_OP_RESET    3'h5
// mode codes
`define TEC_MODE_CW     2'h1
`define TEC_MODE_PD     2'h2
`define TEC_MODE_AB     2'h3
// result fields
`define TEC_RES_Q_BIT    0
`define TEC_RES_DONE_BIT 1
`endif

// file: hdl/tec_axis.v
`timescale 1ns/1ps
`include "tec_regs.vh"
// one encoder axis: input decode and counter
module tec_axis #(
   parameter CW = 32
) (
   // clock and reset
   input  wire          pclk,
   input  wire          presetn,
   // synchronised, inversion-corrected inputs
   input  wire          in_a,
   input  wire          in_b,
   input  wire [1:0]    mode,
   // control
   input  wire          run,
   input  wire          load,
   input  wire [CW-1:0] load_val,
   // count
   output reg  [CW-1:0] count_ff
);
   reg        a_ff;
   reg        b_ff;
   reg        up;
   reg        dn;
   reg [1:0]  emode;
   wire       a_rise = in_a & ~a_ff;
   wire       b_rise = in_b & ~b_ff;
   wire       a_chg  = in_a ^ a_ff;
   wire       b_chg  = in_b ^ b_ff;

   always @* begin
      emode = mode;
      if (mode == 2'h0) begin
         emode = `TEC_MODE_CW;
      end
      up = 1'b0;
      dn = 1'b0;
      case (emode)
         `TEC_MODE_PD: begin
            // a is pulse, b is direction (inversion applied upstream)
            up = a_rise & in_b;
            dn = a_rise & ~in_b;
         end
         `TEC_MODE_AB: begin
            // one step per valid edge, both changing is an illegal jump
            if (a_chg ^ b_chg) begin
               up = (a_chg & (in_a ^ in_b)) | (b_chg & ~(in_a ^ in_b));
               dn = (a_chg & ~(in_a ^ in_b)) | (b_chg & (in_a ^ in_b));
            end
         end
         default: begin
            up = a_rise;
            dn = b_rise;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_ff     <= 1'b0;
         b_ff     <= 1'b0;
         count_ff <= {CW{1'b0}};
      end else begin
         a_ff <= in_a;
         b_ff <= in_b;
         if (load) begin
            count_ff <= load_val;
         end else if (run && (up != dn)) begin
            count_ff <= up ? count_ff + 1'b1 : count_ff - 1'b1;
         end
      end
   end
endmodule // tec_axis

// file: verification/tec_counter_props.sv
`timescale 1ns/1ps
module tec_counter_props (
   // apb
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // index
   input wire [2:0]  enc_z,
   input wire        x_index_flag
);
   reg  [8:0] cfg_ff;
   wire       acc = psel && penable;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cfg_ff <= 9'h015;
      else if (acc && pwrite && paddr == 12'h000)
         cfg_ff <= pwdata[8:0] & 9'h13f;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ready_access: assert property (pready == acc) else $error("pready outside access");
   chk_ready_single: assert property (pready |=> !pready) else $error("pready held");
   chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   chk_err_unmapped: assert property (acc && paddr > 12'h01c |-> pslverr) else $error("no pslverr");
   chk_err_mapped:
      assert property (acc && paddr[1:0] == 2'h0 && paddr <= 12'h01c |-> !pslverr)
      else $error("stray pslverr");
   chk_cmd_zero:
      assert property (acc && !pwrite && paddr == 12'h004 |-> prdata == 32'h0)
      else $error("cmd read not 0");
   chk_cfg_back:
      assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[8:0] == cfg_ff)
      else $error("cfg readback");
   chk_index_follow:
      assert property (cfg_ff[8] == $past(cfg_ff[8], 4)
      |-> x_index_flag == ($past(enc_z[0], 3) ^ cfg_ff[8])) else $error("index flag");
endmodule // tec_counter_props
bind tec_counter tec_counter_props chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .enc_z(enc_z), .x_index_flag(x_index_flag));

// file: verification/tec_enc_model.sv
`timescale 1ns/1ps
module tec_enc_model (
   // clock
   input wire       pclk,
   // encoder pins
   output reg [2:0] enc_a,
   output reg [2:0] enc_b,
   output reg [2:0] enc_z
);
   initial begin
      enc_a = 3'h0;
      enc_b = 3'h0;
      enc_z = 3'h0;
   end
   // toggle one pin, then hold it past the sync stages
   task automatic flip(input integer sel, input integer ax);
      case (sel)
         0: enc_a[ax] <= ~enc_a[ax];
         1: enc_b[ax] <= ~enc_b[ax];
         default: enc_z[ax] <= ~enc_z[ax];
      endcase
      repeat (4) @(posedge pclk);
   endtask
   task automatic pulse(input integer sel, input integer ax, input integer n);
      repeat (2 * n) flip(sel, ax);
   endtask
   // a leads b when up
   task automatic quad(input integer ax, input bit up, input integer n);
      repeat (n) flip(((enc_a[ax] == enc_b[ax]) ^ up) ? 1 : 0, ax);
   endtask
endmodule // tec_enc_model

// file: verification/tb_three_axis_encoder_counter.sv
`timescale 1ns/1ps
module tb_three_axis_encoder_counter;
   reg          pclk = 1'b0;
   reg          presetn = 1'b0;
   reg          psel = 1'b0;
   reg          penable = 1'b0;
   reg          pwrite = 1'b0;
   reg  [11:0]  paddr = 12'h000;
   reg  [31:0]  pwdata = 32'h0;
   wire [31:0]  prdata;
   wire         pready, pslverr, xf, yf, zf;
   wire [2:0]   enc_a, enc_b, enc_z;
   integer      miscompares = 0;
   integer      n_compared = 0;
   logic [31:0] rd;
   logic        er;
   always #25 pclk = ~pclk;
   // host side: one module, driven directly on its apb pins
   tec_counter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a),
      .enc_b(enc_b), .enc_z(enc_z), .x_index_flag(xf), .y_index_flag(yf), .z_index_flag(zf));
   tec_enc_model enc_u (.pclk(pclk), .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z));
   ////////////////////////////////////////////////////////////////////////////
   task automatic summarize;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input bit wr, input logic [11:0] a, input logic [31:0] d);
      integer i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (i >= 20) begin
         chk(32'h0, 32'h1);
         summarize();
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic cmd(input logic [2:0] op, input logic [1:0] ch, input logic [31:0] exp);
      apb(1'b1, 12'h004, {26'h0, ch, 1'b0, op});
      rdc(12'h00c, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      rdc(12'h000, 32'h15);
      rdc(12'h014, 32'h0);
      rdc(12'h010, 32'h0);
      rdc(12'h004, 32'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, er}, 32'h1);
   endtask
   task automatic t_count;
      apb(1'b1, 12'h000, 32'h39);
      cmd(3'h1, 2'h0, 32'h3);
      enc_u.pulse(0, 0, 3);
      enc_u.pulse(1, 0, 1);
      rdc(12'h014, 32'h2);
      cmd(3'h1, 2'h2, 32'h3);
      enc_u.quad(2, 1'b1, 4);
      enc_u.quad(2, 1'b0, 1);
      rdc(12'h01c, 32'h3);
      enc_u.flip(1, 1);
      cmd(3'h1, 2'h1, 32'h3);
      enc_u.pulse(0, 1, 2);
      rdc(12'h018, 32'h2);
   endtask
   task automatic t_stop_load;
      cmd(3'h2, 2'h0, 32'h3);
      enc_u.pulse(0, 0, 2);
      rdc(12'h014, 32'h2);
      cmd(3'h3, 2'h0, 32'h2);
      cmd(3'h4, 2'h0, 32'h3);
      apb(1'b1, 12'h008, 32'h8000_0005);
      cmd(3'h5, 2'h1, 32'h3);
      rdc(12'h018, 32'h8000_0005);
   endtask
   task automatic t_bad;
      cmd(3'h1, 2'h3, 32'h2);
      cmd(3'h6, 2'h0, 32'h2);
      apb(1'b1, 12'h000, 32'h38);
      cmd(3'h1, 2'h0, 32'h3);
      enc_u.pulse(0, 0, 1);
      rdc(12'h014, 32'h3);
      enc_u.flip(2, 1);
      rdc(12'h010, 32'h17);
   endtask
   task automatic t_invert;
      integer k;
      for (k = 0; k < 3; k++)
         cmd(3'h2, k[1:0], 32'h3);
      apb(1'b1, 12'h000, 32'h138);
      cmd(3'h1, 2'h1, 32'h3);
      enc_u.pulse(0, 1, 1);
      rdc(12'h018, 32'h8000_0004);
      rdc(12'h010, 32'h2a);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_count();
      t_stop_load();
      t_bad();
      t_invert();
      summarize();
   end
endmodule // tb_three_axis_encoder_counter
